// >>> hw/emf_framer.sv
// emergency frame builder: queue, sequencer, frame and register port
// Notes on behaviour
// - every frame goes out with identifier 128 plus the node number.
// - bytes 0-1 hold the error code, byte 2 the summary, then extras.
// - extra information bytes not used by an error are zero; the code puts module and channel in bytes 3 and 4 for every code but 0000.
// - summary bits are generic, current, voltage, temp, comms, profile, reserved, maker.
// - a frame is sent on each error event that finds room in the queue, without any remote request.
// - error reset or no error sends code 0000 with bytes 3 to 5 zero.
// - input current too high sends 2110, current bit, module and channel.
// - open circuit or low input current sends 2130 with current bit.
// - output current too high sends 2310 with current bit.
// - output current out of range sends 2323 with current bit.
// - load dump open or low current sends 2330 with current bit.
// - input voltage out of range sends 3003 with voltage bit.
// - the node number lies in 1 to 127 so the identifier stays in band.
`timescale 1ns/100ps
module emf_framer (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic event_stb,
  input wire logic [2:0] event_kind,
  input wire logic [7:0] event_module,
  input wire logic [7:0] event_channel,
  output logic queue_full,
  output logic tx_valid,
  output logic [10:0] tx_id,
  output logic [3:0] tx_dlc,
  output logic [63:0] tx_data,
  input wire logic tx_ready,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq
);

  // ****************************************
  // declarations
  // ****************************************
  emf_pkg::emf_state_e st_r;
  logic [6:0] node_id_r;
  logic [emf_pkg::STAT_W-1:0] status_r;
  logic [emf_pkg::STAT_W-1:0] status_nxt;
  logic [emf_pkg::STAT_W-1:0] mask_r;
  logic [7:0] err_summary_r;
  logic [emf_pkg::QUEUE_AW-1:0] wr_ptr_r;
  logic [emf_pkg::QUEUE_AW-1:0] rd_ptr_r;
  logic [3:0] count_r;
  logic [emf_pkg::ENTRY_W-1:0] rd_entry;
  logic [emf_pkg::ENTRY_W-1:0] wr_entry;
  logic kind_ok;
  logic push;
  logic pop;
  logic overflow_ev;
  logic bad_kind_ev;
  logic sent_ev;
  logic [15:0] map_code;
  logic [7:0] map_summary;
  logic [7:0] map_b3;
  logic [7:0] map_b4;
  logic pend_any;

  // ****************************************
  // event intake
  // ****************************************
  assign kind_ok = (event_kind != emf_pkg::KIND_UNUSED);
  assign push = event_stb && kind_ok && (count_r != emf_pkg::QUEUE_FULL_LEVEL);
  assign overflow_ev = event_stb && kind_ok &&
                       (count_r == emf_pkg::QUEUE_FULL_LEVEL);
  assign bad_kind_ev = event_stb && !kind_ok;
  assign pop = (st_r == emf_pkg::ST_SEND) && tx_valid && tx_ready;
  assign sent_ev = pop;
  assign wr_entry = {event_kind, event_module, event_channel};

  // ****************************************
  // pending queue
  // ****************************************
  emf_queue_mem u_mem (
    .mclk(mclk),
    .wr_en(push),
    .wr_addr(wr_ptr_r),
    .wr_data(wr_entry),
    .rd_addr(rd_ptr_r),
    .rd_data(rd_entry)
  );

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= 4'h0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 3'h1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 3'h1;
      end
      if (push && !pop) begin
        count_r <= count_r + 4'h1;
      end else if (pop && !push) begin
        count_r <= count_r - 4'h1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      queue_full <= 1'b0;
    end else begin
      queue_full <= ((count_r == emf_pkg::QUEUE_FULL_LEVEL) && !pop) ||
                    ((count_r == emf_pkg::QUEUE_FULL_LEVEL - 4'h1) &&
                     push && !pop);
    end
  end

  // ****************************************
  // code lookup
  // ****************************************
  emf_code_map u_map (
    .kind(rd_entry[18:16]),
    .module_no(rd_entry[15:8]),
    .channel_no(rd_entry[7:0]),
    .code(map_code),
    .summary(map_summary),
    .info_b3(map_b3),
    .info_b4(map_b4)
  );

  // ****************************************
  // sequencer
  // ****************************************
  // send on its own initiative
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= emf_pkg::ST_IDLE;
    end else begin
      case (st_r)
        emf_pkg::ST_IDLE: begin
          if (count_r != 4'h0) begin
            st_r <= emf_pkg::ST_FETCH;
          end
        end
        emf_pkg::ST_FETCH: begin
          st_r <= emf_pkg::ST_SEND;
        end
        emf_pkg::ST_SEND: begin
          if (tx_ready) begin
            st_r <= emf_pkg::ST_IDLE;
          end
        end
        default: begin
          st_r <= emf_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // frame assembly
  // ****************************************
  // byte layout of the frame
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_valid <= 1'b0;
      tx_id <= emf_pkg::EMCY_ID_BASE;
      tx_dlc <= emf_pkg::FRAME_DLC;
      tx_data <= '0;
    end else if (st_r == emf_pkg::ST_FETCH) begin
      tx_valid <= 1'b1;
      tx_id <= emf_pkg::EMCY_ID_BASE + {4'h0, node_id_r};
      tx_dlc <= emf_pkg::FRAME_DLC;
      tx_data <= {24'h000000, map_b4, map_b3, map_summary,
                  map_code[15:8], map_code[7:0]};
    end else if (pop) begin
      tx_valid <= 1'b0;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  // node number kept in band
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      node_id_r <= emf_pkg::NODE_ID_RESET;
    end else if (reg_wr && reg_addr == emf_pkg::REG_NODE_ID &&
                 reg_wdata[31:7] == 25'h0 &&
                 reg_wdata[6:0] >= emf_pkg::NODE_ID_MIN) begin
      node_id_r <= reg_wdata[6:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mask_r <= emf_pkg::MASK_RESET;
    end else if (reg_wr && reg_addr == emf_pkg::REG_MASK) begin
      mask_r <= reg_wdata[emf_pkg::STAT_W-1:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      err_summary_r <= emf_pkg::ERR_SUMMARY_RESET;
    end else if (pop) begin
      err_summary_r <= tx_data[23:16];
    end
  end

  always_comb begin
    status_nxt = status_r;
    if (reg_rd && reg_addr == emf_pkg::REG_STATUS) begin
      status_nxt = '0;
    end
    if (sent_ev) begin
      status_nxt[emf_pkg::STAT_SENT] = 1'b1;
    end
    if (overflow_ev) begin
      status_nxt[emf_pkg::STAT_OVERFLOW] = 1'b1;
    end
    if (bad_kind_ev) begin
      status_nxt[emf_pkg::STAT_BAD_KIND] = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      status_r <= emf_pkg::STATUS_RESET;
    end else begin
      status_r <= status_nxt;
    end
  end

  assign pend_any = |(status_r & mask_r);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= pend_any;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        emf_pkg::REG_NODE_ID: reg_rdata <= {25'h0, node_id_r};
        emf_pkg::REG_STATUS: reg_rdata <= {29'h0, status_r};
        emf_pkg::REG_MASK: reg_rdata <= {29'h0, mask_r};
        emf_pkg::REG_ERR_SUMMARY: reg_rdata <= {24'h0, err_summary_r};
        emf_pkg::REG_QUEUE_LEVEL: reg_rdata <= {28'h0, count_r};
        default: reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  sequence s_pending;
    (st_r == emf_pkg::ST_IDLE) && (count_r != 4'h0);
  endsequence

  sequence s_launch;
    ##1 (st_r == emf_pkg::ST_FETCH) ##1 tx_valid;
  endsequence

  sequence s_stall;
    tx_valid && !tx_ready;
  endsequence

  chk_id_band: assert property (
    tx_valid |-> (tx_id[10:7] == 4'h1) && (tx_id[6:0] != 7'h00))
    else $error("emergency identifier out of band");

  chk_node_range: assert property (
    node_id_r != 7'h00)
    else $error("node number zero");

  chk_dlc_eight: assert property (
    tx_valid |-> tx_dlc == 4'h8)
    else $error("frame length not eight");

  chk_pad_zero: assert property (
    tx_valid |-> tx_data[63:40] == 24'h000000)
    else $error("unused bytes not zero");

  chk_clear_frame: assert property (
    tx_valid && tx_data[15:0] == 16'h0000 |-> tx_data[63:16] == '0)
    else $error("error reset frame not all zero");

  chk_current_bit: assert property (
    tx_valid && tx_data[15:12] == 4'h2 |-> tx_data[17] && !tx_data[18])
    else $error("current code without current bit");

  chk_voltage_bit: assert property (
    tx_valid && tx_data[15:0] == 16'h3003 |-> tx_data[18] && !tx_data[17])
    else $error("voltage code without voltage bit");

  chk_summary_bits: assert property (
    tx_valid |-> !tx_data[22] &&
                 (tx_data[16] == (tx_data[15:0] != 16'h0000)))
    else $error("summary generic or reserved bit wrong");

  chk_frame_launch: assert property (
    s_pending |-> s_launch)
    else $error("pending event not launched in two cycles");

  chk_hold_stall: assert property (
    s_stall |=> tx_valid && $stable(tx_data) && $stable(tx_id))
    else $error("frame dropped or changed while stalled");

  chk_irq_level: assert property (
    irq == $past(pend_any))
    else $error("interrupt not raised");

  chk_queue_drop: assert property (
    overflow_ev |=> status_r[emf_pkg::STAT_OVERFLOW] &&
                    (count_r + {3'h0, $past(pop)} == 4'h8))
    else $error("overflow not flagged");

endmodule

// >>> hw/emf_pkg.sv
// constants and types shared by the emergency frame builder
package emf_pkg;

  // ****************************************
  // frame layout
  // ****************************************
  localparam logic [10:0] EMCY_ID_BASE = 11'h080;
  localparam logic [6:0] NODE_ID_MIN = 7'h01;
  localparam logic [6:0] NODE_ID_RESET = 7'h01;
  localparam logic [3:0] FRAME_DLC = 4'h8;
  localparam int BYTE_W = 8;
  localparam int DATA_W = 64;

  // ****************************************
  // emergency error codes
  // ****************************************
  localparam logic [15:0] CODE_NO_ERROR = 16'h0000;
  localparam logic [15:0] CODE_IN_CUR_HIGH = 16'h2110;
  localparam logic [15:0] CODE_IN_CUR_LOW = 16'h2130;
  localparam logic [15:0] CODE_OUT_CUR_HIGH = 16'h2310;
  localparam logic [15:0] CODE_OUT_CUR_RANGE = 16'h2323;
  localparam logic [15:0] CODE_LOAD_DUMP = 16'h2330;
  localparam logic [15:0] CODE_IN_VOLT_RANGE = 16'h3003;

  // ****************************************
  // error summary byte bit positions
  // ****************************************
  localparam int ESB_GENERIC = 0;
  localparam int ESB_CURRENT = 1;
  localparam int ESB_VOLTAGE = 2;
  localparam int ESB_TEMPERATURE = 3;
  localparam int ESB_COMMS = 4;
  localparam int ESB_PROFILE = 5;
  localparam int ESB_RESERVED = 6;
  localparam int ESB_MAKER = 7;

  // ****************************************
  // fault kinds on the event port, all accepted except KIND_UNUSED
  // ****************************************
  typedef enum logic [2:0] {
    KIND_CLEAR = 3'h0,
    KIND_IN_CUR_HIGH = 3'h1,
    KIND_IN_CUR_LOW = 3'h2,
    KIND_OUT_CUR_HIGH = 3'h3,
    KIND_OUT_CUR_RANGE = 3'h4,
    KIND_LOAD_DUMP = 3'h5,
    KIND_IN_VOLT_RANGE = 3'h6,
    KIND_UNUSED = 3'h7
  } emf_kind_e;

  // ****************************************
  // pending queue
  // ****************************************
  localparam int QUEUE_DEPTH = 8;
  localparam int QUEUE_AW = 3;
  localparam int ENTRY_W = 19;
  localparam logic [3:0] QUEUE_FULL_LEVEL = 4'h8;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] REG_NODE_ID = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_MASK = 8'h08;
  localparam logic [7:0] REG_ERR_SUMMARY = 8'h0C;
  localparam logic [7:0] REG_QUEUE_LEVEL = 8'h10;
  localparam int STAT_W = 3;
  localparam int STAT_SENT = 0;
  localparam int STAT_OVERFLOW = 1;
  localparam int STAT_BAD_KIND = 2;
  localparam logic [2:0] STATUS_RESET = 3'h0;
  localparam logic [2:0] MASK_RESET = 3'h0;
  localparam logic [7:0] ERR_SUMMARY_RESET = 8'h00;

  // ****************************************
  // sequencer states
  // ****************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FETCH = 2'b01,
    ST_SEND = 2'b10
  } emf_state_e;

endpackage

// >>> hw/emf_queue_mem.sv
// storage for pending emergency entries, registered read port
`timescale 1ns/100ps
module emf_queue_mem (
  input wire logic mclk,
  input wire logic wr_en,
  input wire logic [emf_pkg::QUEUE_AW-1:0] wr_addr,
  input wire logic [emf_pkg::ENTRY_W-1:0] wr_data,
  input wire logic [emf_pkg::QUEUE_AW-1:0] rd_addr,
  output logic [emf_pkg::ENTRY_W-1:0] rd_data
);

  logic [emf_pkg::ENTRY_W-1:0] mem [emf_pkg::QUEUE_DEPTH];

  // ****************************************
  // write and registered read
  // ****************************************
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule

// >>> hw/emf_code_map.sv
// maps a fault kind onto code, error summary byte and extra bytes
`timescale 1ns/100ps
module emf_code_map (
  input wire logic [2:0] kind,
  input wire logic [7:0] module_no,
  input wire logic [7:0] channel_no,
  output logic [15:0] code,
  output logic [7:0] summary,
  output logic [7:0] info_b3,
  output logic [7:0] info_b4
);

  // ****************************************
  // lookup
  // ****************************************
  always_comb begin
    code = emf_pkg::CODE_NO_ERROR;
    summary = 8'h00;
    info_b3 = module_no;
    info_b4 = channel_no;
    summary[emf_pkg::ESB_GENERIC] = 1'b1;
    case (emf_pkg::emf_kind_e'(kind))
      emf_pkg::KIND_IN_CUR_HIGH: begin
        code = emf_pkg::CODE_IN_CUR_HIGH;
        summary[emf_pkg::ESB_CURRENT] = 1'b1;
      end
      emf_pkg::KIND_IN_CUR_LOW: begin
        code = emf_pkg::CODE_IN_CUR_LOW;
        summary[emf_pkg::ESB_CURRENT] = 1'b1;
      end
      emf_pkg::KIND_OUT_CUR_HIGH: begin
        code = emf_pkg::CODE_OUT_CUR_HIGH;
        summary[emf_pkg::ESB_CURRENT] = 1'b1;
      end
      emf_pkg::KIND_OUT_CUR_RANGE: begin
        code = emf_pkg::CODE_OUT_CUR_RANGE;
        summary[emf_pkg::ESB_CURRENT] = 1'b1;
      end
      emf_pkg::KIND_LOAD_DUMP: begin
        code = emf_pkg::CODE_LOAD_DUMP;
        summary[emf_pkg::ESB_CURRENT] = 1'b1;
      end
      emf_pkg::KIND_IN_VOLT_RANGE: begin
        code = emf_pkg::CODE_IN_VOLT_RANGE;
        summary[emf_pkg::ESB_VOLTAGE] = 1'b1;
      end
      default: begin
        code = emf_pkg::CODE_NO_ERROR;
        summary = 8'h00;
        info_b3 = 8'h00;
        info_b4 = 8'h00;
      end
    endcase
  end

endmodule

// >>> test/emf_can_sink.sv
// behavioural CAN transmitter that takes frames from the framer
`timescale 1ns/100ps
module emf_can_sink (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic tx_valid,
  input wire logic [10:0] tx_id,
  input wire logic [3:0] tx_dlc,
  input wire logic [63:0] tx_data,
  input wire logic stall,
  output logic tx_ready,
  output logic [15:0] frame_cnt,
  output logic [10:0] last_id,
  output logic [3:0] last_dlc,
  output logic [63:0] last_data
);
  // ****************************************
  // ready follows inverted stall one cycle late, frame taken on handshake
  // ****************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_ready <= 1'b0;
      frame_cnt <= 16'h0000;
      last_id <= 11'h000;
      last_dlc <= 4'h0;
      last_data <= 64'h0000000000000000;
    end else begin
      tx_ready <= !stall;
      if (tx_valid && tx_ready) begin
        frame_cnt <= frame_cnt + 16'h0001;
        last_id <= tx_id;
        last_dlc <= tx_dlc;
        last_data <= tx_data;
      end
    end
  end
endmodule

// >>> test/testbench.sv
// self-checking bench for the emergency frame builder
`timescale 1ns/100ps
module testbench;
  typedef struct packed {
    logic [2:0] kind;
    logic [15:0] code;
    logic [7:0] summ;
  } emf_row_s;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic event_stb = 1'b0;
  logic [2:0] event_kind = 3'h0;
  logic [7:0] event_module = 8'h00;
  logic [7:0] event_channel = 8'h00;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h00000000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic stall = 1'b0;
  logic queue_full, tx_valid, tx_ready, irq;
  logic [10:0] tx_id, last_id;
  logic [3:0] tx_dlc, last_dlc;
  logic [63:0] tx_data, last_data;
  logic [31:0] reg_rdata;
  logic [15:0] frame_cnt;
  int error_cnt = 0;
  int num_checks = 0;
  int exp_frames = 0;
  emf_row_s rows [7] = '{
    '{3'h0, 16'h0000, 8'h00}, '{3'h1, 16'h2110, 8'h03},
    '{3'h2, 16'h2130, 8'h03}, '{3'h3, 16'h2310, 8'h03},
    '{3'h4, 16'h2323, 8'h03}, '{3'h5, 16'h2330, 8'h03},
    '{3'h6, 16'h3003, 8'h05}};

  always #25 mclk = ~mclk;

  emf_framer i_emf_framer (.mclk(mclk), .rst_n(rst_n),
    .event_stb(event_stb), .event_kind(event_kind),
    .event_module(event_module), .event_channel(event_channel),
    .queue_full(queue_full), .tx_valid(tx_valid), .tx_id(tx_id),
    .tx_dlc(tx_dlc), .tx_data(tx_data), .tx_ready(tx_ready),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));

  emf_can_sink i_emf_can_sink (.mclk(mclk), .rst_n(rst_n),
    .tx_valid(tx_valid), .tx_id(tx_id), .tx_dlc(tx_dlc),
    .tx_data(tx_data), .stall(stall), .tx_ready(tx_ready),
    .frame_cnt(frame_cnt), .last_id(last_id), .last_dlc(last_dlc),
    .last_data(last_data));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    chk({32'h0, reg_rdata}, {32'h0, exp});
  endtask

  task automatic ev(input logic [2:0] k, input logic [7:0] m,
                    input logic [7:0] c);
    @(posedge mclk);
    event_stb <= 1'b1;
    event_kind <= k;
    event_module <= m;
    event_channel <= c;
  endtask

  task automatic ev_end();
    @(posedge mclk);
    event_stb <= 1'b0;
  endtask

  task automatic frame_chk(input logic [10:0] id, input logic [63:0] d);
    int n;
    n = 0;
    while (frame_cnt != 16'(exp_frames + 1) && n < 60) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 60) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, frame_cnt,
               16'(exp_frames + 1));
    end
    exp_frames++;
    chk({53'h0, last_id}, {53'h0, id});
    chk({60'h0, last_dlc}, {60'h0, emf_pkg::FRAME_DLC});
    chk(last_data, d);
  endtask

  initial begin
    #(50 * 6000);
    error_cnt++;
    give_verdict();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [7:0] m;
    logic [7:0] c;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    chk({61'h0, tx_valid, irq, queue_full}, 64'h0);
    rd(emf_pkg::REG_NODE_ID, 32'h00000001);
    rd(emf_pkg::REG_MASK, 32'h00000000);
    rd(emf_pkg::REG_ERR_SUMMARY, 32'h00000000);
    rd(emf_pkg::REG_QUEUE_LEVEL, 32'h00000000);
    rd(emf_pkg::REG_STATUS, 32'h00000000);
    rd(8'h14, 32'h00000000);
    $display("test reset values done");
    for (int i = 0; i < 7; i++) begin
      m = (i == 0) ? 8'h00 : 8'(8'h10 + i);
      c = (i == 0) ? 8'h00 : 8'(8'h20 + i);
      ev(rows[i].kind, 8'(8'h10 + i), 8'(8'h20 + i));
      ev_end();
      frame_chk(11'h081, {24'h0, c, m, rows[i].summ, rows[i].code});
    end
    rd(emf_pkg::REG_ERR_SUMMARY, 32'h00000005);
    rd(emf_pkg::REG_STATUS, 32'h00000001);
    $display("test code table done");
    wr(emf_pkg::REG_NODE_ID, 32'h00000005);
    wr(emf_pkg::REG_NODE_ID, 32'h00000000);
    rd(emf_pkg::REG_NODE_ID, 32'h00000005);
    wr(emf_pkg::REG_NODE_ID, 32'h00000080);
    rd(emf_pkg::REG_NODE_ID, 32'h00000005);
    ev(3'h3, 8'hA1, 8'hB2);
    ev_end();
    frame_chk(11'h085, 64'h000000B2A1032310);
    wr(emf_pkg::REG_NODE_ID, 32'h0000007F);
    rd(emf_pkg::REG_STATUS, 32'h00000001);
    $display("test node number done");
    @(posedge mclk);
    stall <= 1'b1;
    cycles(2);
    for (int i = 0; i < 9; i++) begin
      ev(3'h1, 8'(i), 8'h07);
    end
    ev_end();
    cycles(3);
    chk({63'h0, queue_full}, 64'h1);
    rd(emf_pkg::REG_QUEUE_LEVEL, 32'h00000008);
    rd(emf_pkg::REG_STATUS, 32'h00000002);
    @(posedge mclk);
    stall <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      frame_chk(11'h0FF, {24'h0, 8'h07, 8'(i), 8'h03, 16'h2110});
      if (i == 0) chk({63'h0, queue_full}, 64'h0);
    end
    cycles(3);
    rd(emf_pkg::REG_QUEUE_LEVEL, 32'h00000000);
    chk({63'h0, queue_full}, 64'h0);
    chk(64'(frame_cnt), 64'(exp_frames));
    rd(emf_pkg::REG_STATUS, 32'h00000001);
    $display("test queue overflow done");
    ev(3'h7, 8'h01, 8'h02);
    ev_end();
    cycles(4);
    chk({63'h0, irq}, 64'h0);
    rd(emf_pkg::REG_STATUS, 32'h00000004);
    wr(emf_pkg::REG_MASK, 32'h00000004);
    rd(emf_pkg::REG_MASK, 32'h00000004);
    ev(3'h7, 8'h01, 8'h02);
    ev_end();
    cycles(4);
    chk({63'h0, irq}, 64'h1);
    chk(64'(frame_cnt), 64'(exp_frames));
    rd(emf_pkg::REG_STATUS, 32'h00000004);
    cycles(3);
    chk({63'h0, irq}, 64'h0);
    $display("test interrupt done");
    @(posedge mclk);
    rst_n <= 1'b0;
    cycles(2);
    chk({61'h0, tx_valid, irq, queue_full}, 64'h0);
    @(posedge mclk);
    rst_n <= 1'b1;
    rd(emf_pkg::REG_NODE_ID, 32'h00000001);
    rd(emf_pkg::REG_MASK, 32'h00000000);
    $display("test mid run reset done");
    give_verdict();
  end
endmodule
